/* File: inc/media_gate_pkg.sv */
package media_gate_pkg;
	// ****************************************
	// Register map, byte addresses
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL0 = 8'h00;
	localparam logic [7:0] OFS_CTRL4 = 8'h04;
	localparam logic [7:0] OFS_XFEAT = 8'h08;
	localparam logic [7:0] OFS_ID_LEAF = 8'h0c;
	localparam logic [7:0] OFS_ID_SUB = 8'h10;
	localparam logic [7:0] OFS_ID_EAX = 8'h14;
	localparam logic [7:0] OFS_ID_EBX = 8'h18;
	localparam logic [7:0] OFS_ID_ECX = 8'h1c;
	localparam logic [7:0] OFS_ID_EDX = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	// Control register field positions
	localparam int B_MONITOR = 1;
	localparam int B_EMULATE = 2;
	localparam int B_TASK_SW = 3;
	localparam int B_FAST_SAVE_OS = 9;
	localparam int B_UNMASKED_OS = 10;
	localparam int B_EXT_SAVE_OS = 18;
	localparam logic [31:0] CTRL0_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL4_RESET = 32'h0000_0000;
	localparam logic [2:0] XFEAT_RESET = 3'h1;
	// ****************************************
	// Identification leaves and bits
	// ****************************************
	localparam logic [31:0] LEAF_STD = 32'h0000_0001;
	localparam logic [31:0] LEAF_EXT = 32'h8000_0001;
	localparam logic [31:0] LEAF_STATE = 32'h0000_000d;
	localparam int ECX_VEC3 = 0;
	localparam int ECX_VEC3S = 9;
	localparam int ECX_VEC41 = 19;
	localparam int ECX_VEC42 = 20;
	localparam int ECX_EXT_SAVE = 26;
	localparam int ECX_EXT_VEC = 28;
	localparam int ECX_BITFIELD = 6;
	localparam int EDX_FP = 0;
	localparam int EDX_MEDIA64 = 23;
	localparam int EDX_FAST_SAVE = 24;
	localparam int EDX_VEC1 = 25;
	localparam int EDX_VEC2 = 26;
	localparam int EDX_FAST_OPT = 25;
	localparam int EAX_OPT_SAVE = 0;
	localparam logic [31:0] AREA_LEGACY = 32'd576;
	localparam logic [31:0] AREA_EXT = 32'd832;
	// ****************************************
	// Instruction subsets and support straps
	// ****************************************
	localparam int S_FP = 0, S_MEDIA64 = 1, S_VEC1 = 2, S_VEC2 = 3, S_VEC3 = 4, S_VEC3S = 5;
	localparam int S_VEC41 = 6, S_VEC42 = 7, S_BITFIELD = 8, S_EXT_VEC = 9, S_FAST_SAVE = 10;
	localparam int S_FAST_OPT = 11, S_EXT_SAVE = 12, S_OPT_SAVE = 13, S_NUM = 14;
	localparam logic [S_NUM-1:0] SUPPORT_RAW = 14'h3fff;
	// Extended vector only counts with stack unit and legacy vector present
	localparam logic EXT_VEC_OK = SUPPORT_RAW[S_EXT_VEC] & SUPPORT_RAW[S_FP] & SUPPORT_RAW[S_VEC1];
	localparam logic [S_NUM-1:0] SUPPORT = {SUPPORT_RAW[13:10], EXT_VEC_OK, SUPPORT_RAW[8:0]};
	localparam logic [2:0] STATE_MASK = {SUPPORT[S_EXT_VEC], SUPPORT[S_VEC1], SUPPORT[S_FP]};
	typedef enum logic [3:0] {
		cls_x87, cls_media64, cls_legacy_vec, cls_ext_vec, cls_fast_save, cls_fast_restore,
		cls_ext_save, cls_ext_restore, cls_opt_save, cls_ctrl_write, cls_ctrl_read, cls_fp_wait
	} instr_class_type;
	typedef enum logic [2:0] {
		exc_none, exc_invalid_opcode, exc_device_not_avail, exc_simd_fp, exc_general_protection
	} exc_type;
endpackage : media_gate_pkg

/* File: inc/id_if.sv */
`timescale 1ns/1ps
// Query path between the gate and the identification responder
interface id_if;
	logic [31:0] leaf;
	logic [31:0] subleaf;
	logic [2:0] enabled;
	logic [31:0] eax;
	logic [31:0] ebx;
	logic [31:0] ecx;
	logic [31:0] edx;
	modport asker (output leaf, output subleaf, output enabled, input eax, input ebx, input ecx, input edx);
	modport responder (input leaf, input subleaf, input enabled, output eax, output ebx, output ecx, output edx);
endinterface : id_if

/* File: logic/id_responder.sv */
`timescale 1ns/1ps
module id_responder (
	id_if.responder q
);
	import media_gate_pkg::*;
	// ****************************************
	// Feature words per leaf
	// ****************************************
	// Pure table lookup; the asker registers the answer
	always_comb begin
		q.eax = 32'h0000_0000;
		q.ebx = 32'h0000_0000;
		q.ecx = 32'h0000_0000;
		q.edx = 32'h0000_0000;
		unique case (q.leaf)
			LEAF_STD: begin
				q.edx[EDX_VEC1] = SUPPORT[S_VEC1];
				q.edx[EDX_VEC2] = SUPPORT[S_VEC2];
				q.ecx[ECX_VEC3] = SUPPORT[S_VEC3];
				q.ecx[ECX_VEC3S] = SUPPORT[S_VEC3S];
				q.ecx[ECX_VEC41] = SUPPORT[S_VEC41];
				q.ecx[ECX_VEC42] = SUPPORT[S_VEC42];
				q.edx[EDX_FP] = SUPPORT[S_FP];
				q.edx[EDX_MEDIA64] = SUPPORT[S_MEDIA64];
				q.edx[EDX_FAST_SAVE] = SUPPORT[S_FAST_SAVE];
				q.ecx[ECX_EXT_SAVE] = SUPPORT[S_EXT_SAVE];
				q.ecx[ECX_EXT_VEC] = SUPPORT[S_EXT_VEC];
			end
			LEAF_EXT: begin
				q.ecx[ECX_BITFIELD] = SUPPORT[S_BITFIELD];
				q.edx[EDX_FP] = SUPPORT[S_FP];
				q.edx[EDX_MEDIA64] = SUPPORT[S_MEDIA64];
				q.edx[EDX_FAST_SAVE] = SUPPORT[S_FAST_SAVE];
				q.edx[EDX_FAST_OPT] = SUPPORT[S_FAST_OPT];
			end
			LEAF_STATE: begin
				if (q.subleaf == 32'h0000_0000) begin
					q.eax = {29'h0, STATE_MASK};
					q.ebx = q.enabled[2] ? AREA_EXT : AREA_LEGACY;
					q.ecx = STATE_MASK[2] ? AREA_EXT : AREA_LEGACY;
				end else if (q.subleaf == 32'h0000_0001) begin
					q.eax[EAX_OPT_SAVE] = SUPPORT[S_OPT_SAVE];
				end
			end
			default: begin
			end
		endcase
	end
endmodule : id_responder

/* File: logic/media_gate.sv */
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module media_gate (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [media_gate_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic instr_valid_i,
	input wire media_gate_pkg::instr_class_type instr_class_i,
	input wire logic [3:0] instr_subset_i,
	input wire logic instr_priv_i,
	input wire logic [31:0] instr_operand_i,
	input wire logic simd_fault_i,
	input wire logic simd_fault_masked_i,
	output logic done_o,
	output media_gate_pkg::exc_type exc_o,
	output logic [31:0] read_value_o
);
	import media_gate_pkg::*;

	// ****************************************
	// State
	// ****************************************
	logic [31:0] ctrl0_reg;
	logic [31:0] ctrl4_reg;
	logic [2:0] xfeat_reg;
	logic [31:0] leaf_reg;
	logic [31:0] subleaf_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic done_reg;
	exc_type exc_reg;
	exc_type exc_next;
	logic [31:0] read_value_reg;
	logic [15:0] exc_count_reg;
	logic xfeat_load;
	logic [31:0] rd_word;
	logic rd_hit;
	logic bus_write;
	logic subset_ok;
	logic is_vec;
	logic is_fp_family;
	logic is_save_family;
	logic is_ctrl;
	logic value_ok;
	logic emulate;
	logic monitor;
	logic task_sw;
	logic fast_save_os;
	logic unmasked_os;
	logic ext_save_os;

	// Identification table lives in its own module; only the selectors are kept here
	id_if idq ();

	id_responder u_id (
		.q(idq.responder)
	);

	assign idq.leaf = leaf_reg;
	assign idq.subleaf = subleaf_reg;
	assign idq.enabled = xfeat_reg;

	// ****************************************
	// Decode helpers
	// ****************************************
	// Only the write path uses this map check; the read mux decodes the address on its own
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		unique case (a)
			OFS_CTRL0, OFS_CTRL4, OFS_XFEAT, OFS_ID_LEAF, OFS_ID_SUB,
			OFS_ID_EAX, OFS_ID_EBX, OFS_ID_ECX, OFS_ID_EDX, OFS_STATUS: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	// Subset an instruction needs; legacy vector names its own revision
	function automatic logic [3:0] class_subset(input instr_class_type c, input logic [3:0] s);
		unique case (c)
			cls_x87, cls_fp_wait: class_subset = 4'(S_FP);
			cls_media64: class_subset = 4'(S_MEDIA64);
			cls_legacy_vec: class_subset = s;
			cls_ext_vec: class_subset = 4'(S_EXT_VEC);
			cls_fast_save, cls_fast_restore: class_subset = 4'(S_FAST_SAVE);
			cls_opt_save: class_subset = 4'(S_OPT_SAVE);
			cls_ext_save, cls_ext_restore, cls_ctrl_write, cls_ctrl_read: class_subset = 4'(S_EXT_SAVE);
			// Codes past the enum can reach the pin; they land past the table
			default: class_subset = 4'hf;
		endcase
	endfunction : class_subset

	// Control bits as named levels
	assign emulate = ctrl0_reg[B_EMULATE];
	assign monitor = ctrl0_reg[B_MONITOR];
	assign task_sw = ctrl0_reg[B_TASK_SW];
	assign fast_save_os = ctrl4_reg[B_FAST_SAVE_OS];
	assign unmasked_os = ctrl4_reg[B_UNMASKED_OS];
	assign ext_save_os = ctrl4_reg[B_EXT_SAVE_OS];

	// ****************************************
	// Instruction gating
	// ****************************************
	// Unknown subset codes past the table count as unimplemented
	assign subset_ok = (class_subset(instr_class_i, instr_subset_i) < 4'(S_NUM))
		&& SUPPORT[class_subset(instr_class_i, instr_subset_i)];
	assign is_vec = (instr_class_i == cls_legacy_vec) || (instr_class_i == cls_ext_vec);
	assign is_save_family = (instr_class_i == cls_ext_save) || (instr_class_i == cls_ext_restore)
		|| (instr_class_i == cls_opt_save);
	assign is_ctrl = (instr_class_i == cls_ctrl_write) || (instr_class_i == cls_ctrl_read);
	assign is_fp_family = (instr_class_i == cls_x87) || (instr_class_i == cls_media64) || is_vec
		|| (instr_class_i == cls_fast_save) || (instr_class_i == cls_fast_restore)
		|| (instr_class_i == cls_fp_wait);
	// Mask value hardware accepts; bad ones are refused, not stored
	assign value_ok = instr_operand_i[0]
		&& !(instr_operand_i[2] && !instr_operand_i[1])
		&& (instr_operand_i[31:3] == 29'h0) && ((instr_operand_i[2:0] & ~STATE_MASK) == 3'h0);

	// ****************************************
	// Gating causes
	// ****************************************
	// One named cause per gate, so the chain below reads in rule order
	logic legacy_no_os;
	logic legacy_emulated;
	logic ext_vec_off;
	logic save_off;
	logic ctrl_off;
	logic ctrl_unpriv;
	logic ctrl_bad_value;
	logic fast_save_emulated;
	logic lazy_trap;
	logic fault_unmasked;
	assign legacy_no_os = (instr_class_i == cls_legacy_vec) && !fast_save_os;
	assign legacy_emulated = (instr_class_i == cls_legacy_vec) && emulate;
	// Wide vector needs both vector state bits of the mask, not just its own
	assign ext_vec_off = (instr_class_i == cls_ext_vec) && !(ext_save_os && xfeat_reg[2] && xfeat_reg[1]);
	assign save_off = is_save_family && !ext_save_os;
	assign ctrl_off = is_ctrl && !ext_save_os;
	assign ctrl_unpriv = (instr_class_i == cls_ctrl_write) && !instr_priv_i;
	assign ctrl_bad_value = (instr_class_i == cls_ctrl_write) && !value_ok;
	assign fast_save_emulated = ((instr_class_i == cls_fast_save) || (instr_class_i == cls_fast_restore))
		&& emulate;
	// Lazy switch trap, off with emulate set; the gates above catch only legacy vector and fast save/restore under emulate
	assign lazy_trap = is_fp_family && !emulate && monitor && task_sw;
	assign fault_unmasked = is_vec && simd_fault_i && !simd_fault_masked_i;

	// Order of checks sets priority: invalid-opcode gates first; the unmasked fault, which can also give invalid opcode, is last
	always_comb begin
		exc_next = exc_none;
		if (!subset_ok) begin
			exc_next = exc_invalid_opcode;
		end else if (legacy_no_os) begin
			exc_next = exc_invalid_opcode;
		end else if (legacy_emulated) begin
			exc_next = exc_invalid_opcode;
		end else if (ext_vec_off) begin
			exc_next = exc_invalid_opcode;
		end else if (save_off) begin
			exc_next = exc_invalid_opcode;
		end else if (ctrl_off) begin
			exc_next = exc_invalid_opcode;
		end else if (ctrl_unpriv) begin
			exc_next = exc_general_protection;
		end else if (ctrl_bad_value) begin
			exc_next = exc_general_protection;
		end else if (fast_save_emulated) begin
			exc_next = exc_device_not_avail;
		end else if (lazy_trap) begin
			exc_next = exc_device_not_avail;
		end else if (fault_unmasked) begin
			exc_next = unmasked_os ? exc_simd_fp : exc_invalid_opcode;
		end
		// A masked fault falls through with no exception
	end

	// Mask loads only when every gate passed for a control write
	assign xfeat_load = instr_valid_i && (instr_class_i == cls_ctrl_write) && (exc_next == exc_none);

	// Result of each instruction check, one cycle after it is offered
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			done_reg <= 1'b0;
			exc_reg <= exc_none;
		end else if (ce_i) begin
			done_reg <= instr_valid_i;
			if (instr_valid_i) begin
				exc_reg <= exc_next;
			end
		end
	end

	// Mask read result; any other offer clears it, so a stale mask never shows
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			read_value_reg <= 32'h0000_0000;
		end else if (ce_i && instr_valid_i) begin
			if ((instr_class_i == cls_ctrl_read) && (exc_next == exc_none)) begin
				read_value_reg <= {29'h0, xfeat_reg};
			end else begin
				read_value_reg <= 32'h0000_0000;
			end
		end
	end

	// Exception tally for software to watch; wraps silently
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			exc_count_reg <= 16'h0000;
		end else if (ce_i && instr_valid_i && (exc_next != exc_none)) begin
			exc_count_reg <= exc_count_reg + 16'h0001;
		end
	end

	// ****************************************
	// Enabled feature mask
	// ****************************************
	// Written only by a privileged control write, never over the bus
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			xfeat_reg <= XFEAT_RESET;
		end else if (ce_i && xfeat_load) begin
			xfeat_reg <= instr_operand_i[2:0];
		end
	end

	// ****************************************
	// APB slave
	// ****************************************
	// One wait state keeps every bus output a plain flop
	assign bus_write = psel_i && penable_i && pready_reg && pwrite_i && is_mapped(paddr_i);

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (paddr_i)
			OFS_CTRL0: rd_word = ctrl0_reg;
			OFS_CTRL4: rd_word = ctrl4_reg;
			OFS_XFEAT: rd_word = {29'h0, xfeat_reg};
			OFS_ID_LEAF: rd_word = leaf_reg;
			OFS_ID_SUB: rd_word = subleaf_reg;
			OFS_ID_EAX: rd_word = idq.eax;
			OFS_ID_EBX: rd_word = idq.ebx;
			OFS_ID_ECX: rd_word = idq.ecx;
			OFS_ID_EDX: rd_word = idq.edx;
			OFS_STATUS: rd_word = {13'h0, exc_reg, exc_count_reg};
			default: rd_hit = 1'b0;
		endcase
	end

	// Handshake and read capture
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else if (ce_i) begin
			pready_reg <= psel_i && penable_i && !pready_reg;
			if (psel_i && penable_i && !pready_reg) begin
				pslverr_reg <= !rd_hit;
				prdata_reg <= pwrite_i ? 32'h0000_0000 : rd_word;
			end else begin
				pslverr_reg <= 1'b0;
				prdata_reg <= 32'h0000_0000;
			end
		end
	end

	// Control word 0; only the three trap bits are kept, the rest read 0
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl0_reg <= CTRL0_RESET;
		end else if (ce_i && bus_write && (paddr_i == OFS_CTRL0)) begin
			ctrl0_reg <= pwdata_i & ((32'h1 << B_MONITOR) | (32'h1 << B_EMULATE) | (32'h1 << B_TASK_SW));
		end
	end

	// Control word 4; only the three OS support bits are kept
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl4_reg <= CTRL4_RESET;
		end else if (ce_i && bus_write && (paddr_i == OFS_CTRL4)) begin
			ctrl4_reg <= pwdata_i & ((32'h1 << B_FAST_SAVE_OS) | (32'h1 << B_UNMASKED_OS)
				| (32'h1 << B_EXT_SAVE_OS));
		end
	end

	// Identification leaf selector
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			leaf_reg <= 32'h0000_0000;
		end else if (ce_i && bus_write && (paddr_i == OFS_ID_LEAF)) begin
			leaf_reg <= pwdata_i;
		end
	end

	// Sub-leaf selector; only the state leaf looks at it
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			subleaf_reg <= 32'h0000_0000;
		end else if (ce_i && bus_write && (paddr_i == OFS_ID_SUB)) begin
			subleaf_reg <= pwdata_i;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata_o = prdata_reg;
	assign pready_o = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign done_o = done_reg;
	assign exc_o = exc_reg;
	assign read_value_o = read_value_reg;
endmodule : media_gate

/* File: verif/media_gate_monitor.sv */
`timescale 1ns/1ps
module media_gate_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [media_gate_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic instr_valid_i,
	input wire media_gate_pkg::instr_class_type instr_class_i,
	input wire logic [3:0] instr_subset_i,
	input wire logic instr_priv_i,
	input wire logic simd_fault_i,
	input wire logic simd_fault_masked_i,
	input wire logic done_o,
	input wire media_gate_pkg::exc_type exc_o
);
	import media_gate_pkg::*;
	logic [31:0] ctrl0_reg;
	logic [31:0] ctrl4_reg;
	logic wr_done;
	logic vec_ok;
	// Writes land at the pready edge, as the bus defines
	assign wr_done = psel_i && penable_i && pready_o && pwrite_i && ce_i;
	// Enabled vector op that reaches the fault stage
	assign vec_ok = instr_valid_i && instr_class_i == cls_legacy_vec && ctrl4_reg[B_FAST_SAVE_OS]
		&& !ctrl0_reg[B_EMULATE] && !ctrl0_reg[B_TASK_SW] && instr_subset_i inside {[S_VEC1:S_BITFIELD]} && simd_fault_i;
	// ****************************************
	// Shadow control words
	// ****************************************
	// Stale if a write and an instruction share one edge; the bench keeps them apart
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl0_reg <= CTRL0_RESET;
			ctrl4_reg <= CTRL4_RESET;
		end else if (wr_done && paddr_i == OFS_CTRL0) begin
			ctrl0_reg <= pwdata_i;
		end else if (wr_done && paddr_i == OFS_CTRL4) begin
			ctrl4_reg <= pwdata_i;
		end
	end
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	one_wait_a: assert property (ce_i && psel_i && penable_i && !pready_o |=> pready_o)
		else $error("bus answer not after one wait state");
	ready_pulse_a: assert property (ce_i && pready_o |=> !pready_o)
		else $error("pready longer than one cycle");
	error_with_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("pslverr without pready");
	idle_data_zero_a: assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("read data outside answer cycle");
	done_timing_a: assert property (ce_i |=> done_o == $past(instr_valid_i))
		else $error("done not one cycle after offer");
	fast_save_ud_a: assert property (instr_valid_i && instr_class_i == cls_legacy_vec
		&& !ctrl4_reg[B_FAST_SAVE_OS] |=> exc_o == exc_invalid_opcode)
		else $error("vector op ran without fast save support");
	emulate_ud_a: assert property (instr_valid_i && instr_class_i == cls_legacy_vec && ctrl0_reg[B_EMULATE]
		|=> exc_o == exc_invalid_opcode) else $error("vector op ran under emulation");
	emulate_nm_a: assert property (instr_valid_i && instr_class_i inside {cls_fast_save, cls_fast_restore}
		&& ctrl0_reg[B_EMULATE] |=> exc_o == exc_device_not_avail) else $error("fast save ran under emulation");
	lazy_trap_a: assert property (instr_valid_i && instr_class_i inside {cls_x87, cls_media64, cls_fp_wait}
		&& !ctrl0_reg[B_EMULATE] && ctrl0_reg[B_MONITOR] && ctrl0_reg[B_TASK_SW] |=> exc_o == exc_device_not_avail)
		else $error("task switch trap missing");
	ctrl_gate_a: assert property (instr_valid_i && instr_class_i inside {cls_ctrl_write, cls_ctrl_read}
		&& !ctrl4_reg[B_EXT_SAVE_OS] |=> exc_o == exc_invalid_opcode) else $error("control access not gated");
	priv_write_a: assert property (instr_valid_i && instr_class_i == cls_ctrl_write && ctrl4_reg[B_EXT_SAVE_OS]
		&& !instr_priv_i |=> exc_o == exc_general_protection) else $error("unprivileged control write taken");
	fault_route_a: assert property (vec_ok && !simd_fault_masked_i
		|=> exc_o == (ctrl4_reg[B_UNMASKED_OS] ? exc_simd_fp : exc_invalid_opcode)) else $error("fault misrouted");
	masked_fault_a: assert property (vec_ok && simd_fault_masked_i |=> exc_o == exc_none)
		else $error("masked fault raised exception");
endmodule : media_gate_monitor
bind media_gate media_gate_monitor i_monitor (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .instr_valid_i(instr_valid_i), .instr_class_i(instr_class_i),
	.instr_subset_i(instr_subset_i), .instr_priv_i(instr_priv_i), .simd_fault_i(simd_fault_i),
	.simd_fault_masked_i(simd_fault_masked_i), .done_o(done_o), .exc_o(exc_o));

/* File: verif/media_gate_bench.sv */
`timescale 1ns/1ps
module media_gate_bench;
	import media_gate_pkg::*;
	logic clk_i;
	logic rst_i;
	logic ce_i;
	logic psel_i;
	logic penable_i;
	logic pwrite_i;
	logic [ADDR_W-1:0] paddr_i;
	logic [31:0] pwdata_i;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic instr_valid_i;
	instr_class_type instr_class_i;
	logic [3:0] instr_subset_i;
	logic instr_priv_i;
	logic [31:0] instr_operand_i;
	logic simd_fault_i;
	logic simd_fault_masked_i;
	logic done_o;
	exc_type exc_o;
	logic [31:0] read_value_o;
	int n_mismatch;
	int checks;
	// Leaf, subleaf, then the expected four answer words
	logic [31:0] id_tab [5][6] = '{
		'{LEAF_STD, 32'h0, 32'h0, 32'h0, 32'h1418_0201, 32'h0780_0001},
		'{LEAF_EXT, 32'h0, 32'h0, 32'h0, 32'h0000_0040, 32'h0380_0001},
		'{LEAF_STATE, 32'h0, 32'h7, 32'h240, 32'h340, 32'h0},
		'{LEAF_STATE, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0},
		'{32'h2, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0}};
	instr_class_type fp_cls [5] = '{cls_x87, cls_media64, cls_fp_wait, cls_legacy_vec, cls_fast_save};
	media_gate i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .instr_valid_i(instr_valid_i), .instr_class_i(instr_class_i),
		.instr_subset_i(instr_subset_i), .instr_priv_i(instr_priv_i), .instr_operand_i(instr_operand_i),
		.simd_fault_i(simd_fault_i), .simd_fault_masked_i(simd_fault_masked_i), .done_o(done_o), .exc_o(exc_o),
		.read_value_o(read_value_o));
	// ****************************************
	// Clock and watchdog
	// ****************************************
	initial begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end
	// Run needs well under a thousand cycles; generous margin
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		end_sim();
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask : check
	// One bus transfer; the request holds until pready is sampled high
	task automatic bus(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] data,
		input logic [31:0] exp, input logic err);
		@(posedge clk_i);
		psel_i <= 1'h1;
		penable_i <= 1'h0;
		pwrite_i <= wr;
		paddr_i <= addr;
		pwdata_i <= data;
		@(posedge clk_i);
		penable_i <= 1'h1;
		// Waits for the answer; only the watchdog ends a hang
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'h1);
		if (wr === 1'h0) check(prdata_o, exp);
		check({31'h0, pslverr_o}, {31'h0, err});
		psel_i <= 1'h0;
		penable_i <= 1'h0;
	endtask : bus
	task automatic wr(input logic [ADDR_W-1:0] addr, input logic [31:0] data);
		bus(1'h1, addr, data, 32'h0, 1'h0);
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] addr, input logic [31:0] exp);
		bus(1'h0, addr, 32'h0, exp, 1'h0);
	endtask : rd
	// Offer one instruction; result is due in the next cycle
	task automatic issue(input instr_class_type cls, input exc_type exp_e, input logic [1:0] flt = 2'h0,
		input logic [31:0] exp_v = 32'h0, input logic [31:0] opnd = 32'h0, input logic priv = 1'h1,
		input logic [3:0] sub = 4'h2);
		@(posedge clk_i);
		instr_valid_i <= 1'h1;
		instr_class_i <= cls;
		instr_subset_i <= sub;
		instr_priv_i <= priv;
		instr_operand_i <= opnd;
		simd_fault_i <= flt[1];
		simd_fault_masked_i <= flt[0];
		@(posedge clk_i);
		instr_valid_i <= 1'h0;
		@(posedge clk_i);
		check({31'h0, done_o}, 32'h1);
		check({29'h0, exc_o}, {29'h0, exp_e});
		check(read_value_o, exp_v);
	endtask : issue
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		ce_i = 1'h1;
		rst_i = 1'h1;
		{psel_i, penable_i, pwrite_i, instr_valid_i, instr_priv_i, simd_fault_i, simd_fault_masked_i} = 7'h0;
		{paddr_i, pwdata_i, instr_operand_i, instr_subset_i} = '0;
		instr_class_i = cls_x87;
		n_mismatch = 0;
		checks = 0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'h0;
		// Reset values, then an unmapped place both ways
		rd(OFS_CTRL0, CTRL0_RESET);
		rd(OFS_CTRL4, CTRL4_RESET);
		rd(OFS_XFEAT, {29'h0, XFEAT_RESET});
		bus(1'h0, 8'h28, 32'h0, 32'h0, 1'h1);
		bus(1'h1, 8'h28, 32'hffff_ffff, 32'h0, 1'h1);
		// Identification answers, leaf by leaf
		for (int i = 0; i < 5; i++) begin
			wr(OFS_ID_LEAF, id_tab[i][0]);
			wr(OFS_ID_SUB, id_tab[i][1]);
			for (int j = 0; j < 4; j++) rd(OFS_ID_EAX + 8'(4 * j), id_tab[i][j + 2]);
		end
		// Missing fast save support outranks the task-switch trap
		wr(OFS_CTRL0, 32'ha);
		issue(cls_legacy_vec, exc_invalid_opcode);
		wr(OFS_CTRL4, 32'h200);
		foreach (fp_cls[k]) issue(fp_cls[k], exc_device_not_avail);
		// Emulation on
		wr(OFS_CTRL0, 32'h4);
		issue(cls_legacy_vec, exc_invalid_opcode);
		issue(cls_fast_save, exc_device_not_avail);
		issue(cls_fast_restore, exc_device_not_avail);
		// Monitor alone traps nothing; every subset from S_VEC1 to S_BITFIELD runs
		wr(OFS_CTRL0, 32'h2);
		for (int s = S_VEC1; s <= S_BITFIELD; s++) issue(cls_legacy_vec, exc_none, 2'h0, 32'h0, 32'h0, 1'h1, 4'(s));
		issue(cls_x87, exc_none);
		issue(cls_ctrl_read, exc_invalid_opcode);
		issue(cls_ctrl_write, exc_invalid_opcode, 2'h0, 32'h0, 32'h7);
		// Mask writes once extended save is enabled; bad values leave it alone
		wr(OFS_CTRL4, 32'h4_0200);
		issue(cls_ctrl_write, exc_general_protection, 2'h0, 32'h0, 32'h7, 1'h0);
		issue(cls_ctrl_write, exc_general_protection, 2'h0, 32'h0, 32'h5);
		issue(cls_ctrl_write, exc_general_protection, 2'h0, 32'h0, 32'h6);
		issue(cls_ctrl_read, exc_none, 2'h0, 32'h1);
		issue(cls_ext_vec, exc_invalid_opcode);
		issue(cls_ctrl_write, exc_none, 2'h0, 32'h0, 32'h7);
		issue(cls_ctrl_read, exc_none, 2'h0, 32'h7);
		issue(cls_ext_vec, exc_none);
		issue(cls_ext_save, exc_none);
		wr(OFS_XFEAT, 32'h0);
		rd(OFS_XFEAT, 32'h7);
		wr(OFS_ID_LEAF, LEAF_STATE);
		wr(OFS_ID_SUB, 32'h0);
		rd(OFS_ID_EBX, AREA_EXT);
		// Fault routing follows the handler bit; masked faults stay quiet
		issue(cls_legacy_vec, exc_invalid_opcode, 2'h2);
		issue(cls_legacy_vec, exc_none, 2'h3);
		wr(OFS_CTRL4, 32'h4_0600);
		issue(cls_legacy_vec, exc_simd_fp, 2'h2);
		rd(OFS_STATUS, {13'h0, exc_simd_fp, 16'h0011});
		issue(cls_legacy_vec, exc_none, 2'h3);
		// Frozen enable: a control read offered now is not taken
		@(posedge clk_i);
		ce_i <= 1'h0;
		instr_valid_i <= 1'h1;
		instr_class_i <= cls_ctrl_read;
		@(posedge clk_i);
		ce_i <= 1'h1;
		instr_valid_i <= 1'h0;
		@(posedge clk_i);
		check({31'h0, done_o}, 32'h0);
		check(read_value_o, 32'h0);
		end_sim();
	end
endmodule : media_gate_bench
